//--- hdl/ssp_core.v
// Synchronous serial port, SPI master/slave with I2C status bits, AXI4-Lite registers
// Function
// - Edge select with polarity picks shift edge
// - I2C data/address bit tracks last byte
// - I2C read/write bit captured on match
// - Buffer write during transfer sets collision
// - Slave byte into full buffer: overflow, drop
// - Overflow set only in slave and I2C modes
// - Master transfer starts on buffer write
// - I2C data byte into full buffer: overflow, software clears
// - Enable hands clock and data pins over
// - Enable in I2C modes drives SCL low only while polarity clear; SDA never driven
// - Polarity bit sets idle clock level
// - I2C polarity clear holds SCL low
// - Mode 0000 SCK at half aclk rate, 0011 SCK at a quarter of timer2 rate
// - Modes 0100/0101 slave with/without select
// - Modes 0110/0111/1110/1111 I2C slave addressing
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_core #(
  parameter DIV16 = 4,
  parameter DIV64 = 16
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer_two_tick,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        sdi_in,
  output reg         sdo_out,
  output reg         sdo_oe,
  input  wire        ss_n_in,
  output reg         ss_pin_free,
  input  wire        i2c_addr_match,
  input  wire        i2c_addr_rw,
  input  wire        i2c_byte_done,
  input  wire        i2c_byte_is_data
);
  reg  [7:0] port_control_reg;
  reg  [7:0] port_status_reg;
  reg  [7:0] transfer_buffer_reg;
  reg  [7:0] slave_address_reg;
  reg  [7:0] shift_register_reg;
  reg  [2:0] bit_cnt_reg;
  reg        busy_reg;
  reg        sck_int_reg;
  reg        half_reg;
  reg        smp_hold_reg;
  reg        out_bit_reg;
  reg  [5:0] div_cnt_reg;
  reg        t2_half_reg;
  reg        t2_prev_reg;
  reg        sck_prev_reg;
  reg        aw_got_reg;
  reg        w_got_reg;
  reg  [7:0] aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0] w_strb_reg;
  wire       sck_s;
  wire       sdi_s;
  wire       ss_n_s;
  wire [3:0] mode = port_control_reg[3:0];
  wire       en = port_control_reg[`SSP_CTL_EN];
  wire       clock_polarity = port_control_reg[`SSP_CTL_CKP];
  wire       cke = port_status_reg[`SSP_ST_CKE];
  wire       input_sample_phase = port_status_reg[`SSP_ST_SMP];
  wire       is_master = (mode == `SSP_MODE_M_DIV4) || (mode == `SSP_MODE_M_DIV16) ||
                         (mode == `SSP_MODE_M_DIV64) || (mode == `SSP_MODE_M_TIMER_TWO);
  // slave modes, select honoured only in 0100
  wire       is_slave = (mode == `SSP_MODE_S_SS) || (mode == `SSP_MODE_S_NOSS);
  wire       is_i2c = (mode == `SSP_MODE_I2C7) || (mode == `SSP_MODE_I2C10) ||
                      (mode == `SSP_MODE_I2C7_SP) || (mode == `SSP_MODE_I2C10_SP);
  wire       ss_ok = (mode == `SSP_MODE_S_NOSS) || !ss_n_s;

  // Pins are sampled twice before use
  ssp_sync2 u_sck (.aclk(aclk), .aresetn(aresetn), .d(sck_in),  .q(sck_s));
  ssp_sync2 u_sdi (.aclk(aclk), .aresetn(aresetn), .d(sdi_in),  .q(sdi_s));
  ssp_sync2 u_ss  (.aclk(aclk), .aresetn(aresetn), .d(ss_n_in), .q(ss_n_s));

  // Master half-bit tick; timer2 output halved first
  wire       t2_edge = timer_two_tick && !t2_prev_reg;
  reg        tick;
  always @* begin
    case (mode)
      `SSP_MODE_M_DIV4:  tick = 1'b1;
      `SSP_MODE_M_DIV16: tick = (div_cnt_reg == DIV16[5:0] - 6'h01);
      `SSP_MODE_M_DIV64: tick = (div_cnt_reg == DIV64[5:0] - 6'h01);
      `SSP_MODE_M_TIMER_TWO:  tick = t2_edge && t2_half_reg;
      default:           tick = 1'b0;
    endcase
  end

  // Slave clock edges; shift edge depends on polarity and edge select
  wire       sck_rise = sck_s && !sck_prev_reg;
  wire       sck_fall = !sck_s && sck_prev_reg;
  wire       out_on_rise = (clock_polarity != cke);
  wire       s_shift_edge = out_on_rise ? sck_rise : sck_fall;
  wire       s_sample_edge = out_on_rise ? sck_fall : sck_rise;

  // AXI handshakes
  wire       aw_take = s_axi_awvalid && s_axi_awready;
  wire       w_take = s_axi_wvalid && s_axi_wready;
  wire       wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire       rd_go = s_axi_arvalid && s_axi_arready;
  wire       wr_buf = wr_go && aw_addr_reg == `SSP_OFF_BUFFER && w_strb_reg[0];
  wire       rd_buf = rd_go && s_axi_araddr == `SSP_OFF_BUFFER;
  wire       wr_ctl = wr_go && aw_addr_reg == `SSP_OFF_CONTROL && w_strb_reg[0];
  wire       wr_st = wr_go && aw_addr_reg == `SSP_OFF_STATUS && w_strb_reg[0];
  wire       wr_adr = wr_go && aw_addr_reg == `SSP_OFF_ADDRESS && w_strb_reg[0];
  wire       wr_ok = aw_addr_reg == `SSP_OFF_BUFFER || aw_addr_reg == `SSP_OFF_CONTROL ||
                     aw_addr_reg == `SSP_OFF_STATUS || aw_addr_reg == `SSP_OFF_ADDRESS;

  // Byte completion events
  wire       m_done = busy_reg && is_master && tick && half_reg && bit_cnt_reg == 3'h7;
  // Slave receives whenever clocked, loaded or not, so overflow can be seen
  wire       s_done = en && is_slave && ss_ok && s_sample_edge && bit_cnt_reg == 3'h7;
  wire [7:0] m_rx_byte = {shift_register_reg[6:0], smp_hold_reg};
  wire [7:0] s_rx_byte = {shift_register_reg[6:0], sdi_s};

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSP_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !aw_got_reg && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_got_reg && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SSP_RESP_OKAY;
        case (s_axi_araddr)
          `SSP_OFF_CONTROL: s_axi_rdata <= {24'h000000, port_control_reg};
          `SSP_OFF_STATUS:  s_axi_rdata <= {24'h000000, port_status_reg};
          `SSP_OFF_BUFFER:  s_axi_rdata <= {24'h000000, transfer_buffer_reg};
          `SSP_OFF_ADDRESS: s_axi_rdata <= {24'h000000, slave_address_reg};
          `SSP_OFF_PINS:    s_axi_rdata <= {29'h0000000, ss_n_s, sdi_s, sck_s};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SSP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control register: flags set by hardware win over software clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_control_reg <= `SSP_RESET_BYTE;
    end else begin
      if (wr_ctl)
        port_control_reg <= w_data_reg[7:0];
      if (wr_buf && busy_reg)
        port_control_reg[`SSP_CTL_WRITE_COLLISION] <= 1'b1;
      // slave byte lost into full buffer
      if (s_done && port_status_reg[`SSP_ST_BF])
        port_control_reg[`SSP_CTL_OVF] <= 1'b1;
      if (en && is_i2c && i2c_byte_done && i2c_byte_is_data && port_status_reg[`SSP_ST_BF])
        port_control_reg[`SSP_CTL_OVF] <= 1'b1;
    end
  end

  // Status register, buffer and I2C indicators
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_status_reg     <= `SSP_RESET_BYTE;
      transfer_buffer_reg <= `SSP_RESET_BYTE;
      slave_address_reg   <= `SSP_RESET_BYTE;
    end else begin
      if (wr_st)
        port_status_reg[7:6] <= w_data_reg[7:6];
      if (wr_adr)
        slave_address_reg <= w_data_reg[7:0];
      if (rd_buf)
        port_status_reg[`SSP_ST_BF] <= 1'b0;
      if (wr_buf && !busy_reg)
        transfer_buffer_reg <= w_data_reg[7:0];
      if (m_done) begin
        transfer_buffer_reg         <= m_rx_byte;
        port_status_reg[`SSP_ST_BF] <= 1'b1;
      end
      if (s_done && !port_status_reg[`SSP_ST_BF]) begin
        transfer_buffer_reg         <= s_rx_byte;
        port_status_reg[`SSP_ST_BF] <= 1'b1;
      end
      if (en && is_i2c) begin
        if (i2c_addr_match)
          port_status_reg[`SSP_ST_RW] <= i2c_addr_rw;
        if (i2c_byte_done) begin
          port_status_reg[`SSP_ST_DA] <= i2c_byte_is_data;
          if (!port_status_reg[`SSP_ST_BF])
            port_status_reg[`SSP_ST_BF] <= 1'b1;
        end
      end
      if (!en)
        port_status_reg[5:1] <= 5'h00;
    end
  end

  // Shift engine for master and slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      shift_register_reg <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      busy_reg     <= 1'b0;
      half_reg     <= 1'b0;
      smp_hold_reg <= 1'b0;
      out_bit_reg  <= 1'b0;
      sck_int_reg  <= 1'b0;
      div_cnt_reg  <= 6'h00;
      t2_half_reg  <= 1'b0;
      t2_prev_reg  <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      t2_prev_reg  <= timer_two_tick;
      sck_prev_reg <= sck_s;
      if (t2_edge)
        t2_half_reg <= !t2_half_reg;
      div_cnt_reg <= (tick || !busy_reg) ? 6'h00 : div_cnt_reg + 6'h01;
      if (!busy_reg)
        sck_int_reg <= clock_polarity;
      if (!en) begin
        busy_reg <= 1'b0;
      end else if (wr_buf && !busy_reg) begin
        shift_register_reg <= w_data_reg[7:0];
        busy_reg    <= 1'b1;
        bit_cnt_reg <= 3'h0;
        half_reg    <= 1'b0;
      end else if (busy_reg && is_master && tick) begin
        sck_int_reg <= !sck_int_reg;
        half_reg    <= !half_reg;
        // middle sample at leading half, end sample at trailing
        if (!half_reg && !input_sample_phase)
          smp_hold_reg <= sdi_s;
        if (half_reg) begin
          shift_register_reg <= {shift_register_reg[6:0], input_sample_phase ? sdi_s : smp_hold_reg};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
            busy_reg <= 1'b0;
        end
      end else if (is_slave && ss_ok && s_sample_edge) begin
        shift_register_reg <= s_rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7)
          busy_reg <= 1'b0;
      end
      if (busy_reg && is_master && tick && half_reg && input_sample_phase)
        smp_hold_reg <= sdi_s;
      if (!busy_reg && is_master)
        half_reg <= 1'b0;
      // outgoing bit loads on buffer write, then changes only on the selected edge
      if (en && wr_buf && !busy_reg)
        out_bit_reg <= w_data_reg[7];
      else if (busy_reg && is_master && tick && (half_reg != cke))
        out_bit_reg <= half_reg ? shift_register_reg[6] : shift_register_reg[7];
      else if (en && is_slave && ss_ok && s_shift_edge)
        out_bit_reg <= shift_register_reg[7];
    end
  end

  // Pin drivers from flops; pins stay released while disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_out     <= 1'b0;
      sck_oe      <= 1'b0;
      sdo_out     <= 1'b0;
      sdo_oe      <= 1'b0;
      ss_pin_free <= 1'b1;
    end else begin
      sck_out <= is_i2c ? 1'b0 : sck_int_reg;
      sck_oe  <= en && (is_master || (is_i2c && !clock_polarity));
      sdo_out <= out_bit_reg;
      sdo_oe  <= en && (is_master || (is_slave && ss_ok));
      ss_pin_free <= !(en && mode == `SSP_MODE_S_SS);
    end
  end
  // Address register is kept for software only; the I2C engine sits outside
  wire unused_ok = slave_address_reg[0];
endmodule // ssp_core
`default_nettype wire

//--- inc/ssp_defines.vh
// Register map, field positions, mode codes and bus responses of the serial port
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
`define SSP_OFF_CONTROL    8'h14
`define SSP_OFF_STATUS     8'h94
`define SSP_OFF_BUFFER     8'h13
`define SSP_OFF_ADDRESS    8'h93
`define SSP_OFF_PINS       8'h20
`define SSP_CTL_WRITE_COLLISION       7
`define SSP_CTL_OVF        6
`define SSP_CTL_EN         5
`define SSP_CTL_CKP        4
`define SSP_ST_SMP         7
`define SSP_ST_CKE         6
`define SSP_ST_DA          5
`define SSP_ST_STOP        4
`define SSP_ST_START       3
`define SSP_ST_RW          2
`define SSP_ST_UA          1
`define SSP_ST_BF          0
`define SSP_MODE_M_DIV4    4'h0
`define SSP_MODE_M_DIV16   4'h1
`define SSP_MODE_M_DIV64   4'h2
`define SSP_MODE_M_TIMER_TWO    4'h3
`define SSP_MODE_S_SS      4'h4
`define SSP_MODE_S_NOSS    4'h5
`define SSP_MODE_I2C7      4'h6
`define SSP_MODE_I2C10     4'h7
`define SSP_MODE_I2C7_SP   4'he
`define SSP_MODE_I2C10_SP  4'hf
`define SSP_RESET_BYTE     8'h00
`define SSP_RESP_OKAY      2'b00
`define SSP_RESP_SLVERR    2'b10
`endif

//--- hdl/ssp_sync2.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module ssp_sync2 (
  input  wire aclk,
  input  wire aresetn,
  input  wire d,
  output reg  q
);
  reg meta_reg;

  // First flop feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // ssp_sync2
`default_nettype wire

//--- bench/ssp_asserts.sv
// Checker for the serial port register bus
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] ar_q;
  logic [7:0] aw_q;
  // Hold taken addresses so the later answer can be judged
  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= `SSP_OFF_CONTROL;
      aw_q <= `SSP_OFF_CONTROL;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    end
  end
  function automatic logic mapped(input logic [7:0] a);
    return a inside {`SSP_OFF_CONTROL, `SSP_OFF_STATUS, `SSP_OFF_BUFFER,
                     `SSP_OFF_ADDRESS, `SSP_OFF_PINS};
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write answer late");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2];
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rd_err;
    s_axi_rvalid |-> s_axi_rresp == (mapped(ar_q) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR)
      && (mapped(ar_q) || s_axi_rdata == 32'h00000000);
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("read response wrong");
  property p_wr_err;
    s_axi_bvalid |-> s_axi_bresp == (mapped(aw_q) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR);
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("write response wrong");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `SSP_RESP_SLVERR);
endmodule // ssp_asserts
bind ssp_core ssp_asserts u_ssp_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

//--- bench/ssp_peer.sv
// Behavioural SPI peer: slave to a master core, master to a slave core
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
  input  wire logic sck_out,
  input  wire logic sdo_out,
  output var  logic sck_in,
  output var  logic sdi_in,
  output var  logic ss_n_in
);
  logic [7:0] rx_byte;
  logic [7:0] reply;
  initial begin
    sck_in = 1'b0;
    ss_n_in = 1'b1;
    sdi_in = 1'b1;
    rx_byte = 8'h00;
    reply = 8'h00;
  end
  always @(posedge sck_out) rx_byte <= {rx_byte[6:0], sdo_out};
  // shift on falling edge; tail bits keep changing
  always @(negedge sck_out) begin
    sdi_in <= reply[6];
    reply <= {reply[6:0], ~reply[0]};
  end
  task automatic load(input logic [7:0] b);
    reply <= b;
    sdi_in <= b[7];
  endtask
  // peer drives only its own lines; clock still between frames
  task automatic send(input logic [7:0] b);
    // Kept off the core clock edge so the synchronisers never race the pins
    #10 ss_n_in = 1'b0;
    #320;
    for (int i = 7; i >= 0; i--) begin
      sdi_in = b[i];
      #160 rx_byte = {rx_byte[6:0], sdo_out};
      sck_in = 1'b1;
      #160 sck_in = 1'b0;
    end
    #160 ss_n_in = 1'b1;
    sdi_in = ~sdi_in;
  endtask
endmodule // ssp_peer
`default_nettype wire

//--- bench/sync_serial_port_spi_bench.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module sync_serial_port_spi_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, timer_two_tick;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe, ss_n_in, ss_pin_free;
  logic        i2c_addr_match, i2c_addr_rw, i2c_byte_done, i2c_byte_is_data;
  int          num_errors, n_compared, cyc;
  ssp_core #(.DIV16(4), .DIV64(16)) u_ssp_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_two_tick(timer_two_tick), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .ss_n_in(ss_n_in), .ss_pin_free(ss_pin_free),
    .i2c_addr_match(i2c_addr_match), .i2c_addr_rw(i2c_addr_rw),
    .i2c_byte_done(i2c_byte_done), .i2c_byte_is_data(i2c_byte_is_data)
  );
  ssp_peer peer_model (.sck_out(sck_out), .sdo_out(sdo_out), .sck_in(sck_in),
                       .sdi_in(sdi_in), .ss_n_in(ss_n_in));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Free-running timer output and hang guard
  always @(posedge aclk) begin
    timer_two_tick <= ~timer_two_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_bf();
    int n;
    n = 0;
    d = 32'h0;
    while (d[0] !== 1'b1 && n < 300) begin
      rd(`SSP_OFF_STATUS);
      n++;
    end
    check(d[0], 1'b1, "buffer full");
  endtask
  task automatic t_reset();
    rd(`SSP_OFF_CONTROL);
    check(d, 32'h0, "control reset");
    rd(`SSP_OFF_STATUS);
    check(d, 32'h0, "status reset");
    rd(8'h40);
    check({r, d}, {`SSP_RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h44, 32'hff);
    check(r, `SSP_RESP_SLVERR, "unmapped write");
    $display("test reset done");
  endtask
  task automatic t_master();
    wr(`SSP_OFF_CONTROL, 32'h21);
    // Pin outputs settle one edge after the register write
    @(negedge aclk);
    check(sck_oe, 1'b1, "clock pin taken");
    peer_model.load(8'h3c);
    wr(`SSP_OFF_BUFFER, 32'ha5);
    wr(`SSP_OFF_BUFFER, 32'h11);
    wait_bf();
    check(peer_model.rx_byte, 8'ha5, "byte sent");
    rd(`SSP_OFF_BUFFER);
    check(d, 32'h3c, "byte received");
    rd(`SSP_OFF_STATUS);
    check(d[0], 1'b0, "full cleared");
    rd(`SSP_OFF_CONTROL);
    check(d[7:6], 2'b10, "collision, no overflow");
    wr(`SSP_OFF_CONTROL, 32'h21);
    rd(`SSP_OFF_CONTROL);
    check(d[7], 1'b0, "collision cleared");
    check(sck_out, 1'b0, "idle low");
    $display("test master done");
  endtask
  task automatic t_slave();
    wr(`SSP_OFF_CONTROL, 32'h25);
    @(negedge aclk);
    check(ss_pin_free, 1'b1, "select ignored");
    wr(`SSP_OFF_BUFFER, 32'h5a);
    peer_model.send(8'hc3);
    wait_bf();
    check(peer_model.rx_byte, 8'h5a, "slave sent");
    peer_model.send(8'h7e);
    repeat (8) @(posedge aclk);
    rd(`SSP_OFF_CONTROL);
    check(d[6], 1'b1, "overflow");
    rd(`SSP_OFF_BUFFER);
    check(d, 32'hc3, "old byte kept");
    wr(`SSP_OFF_CONTROL, 32'h24);
    @(negedge aclk);
    check(ss_pin_free, 1'b0, "select used");
    $display("test slave done");
  endtask
  task automatic t_rates();
    wr(`SSP_OFF_CONTROL, 32'h30);
    repeat (4) @(posedge aclk);
    check(sck_out, 1'b1, "idle high");
    wr(`SSP_OFF_BUFFER, 32'h96);
    wait_bf();
    rd(`SSP_OFF_BUFFER);
    wr(`SSP_OFF_CONTROL, 32'h23);
    // Clock falls to its new idle level first; load the peer after that edge
    repeat (3) @(posedge aclk);
    peer_model.load(8'hc6);
    wr(`SSP_OFF_BUFFER, 32'h69);
    wait_bf();
    check(peer_model.rx_byte, 8'h69, "timer rate sent");
    rd(`SSP_OFF_BUFFER);
    check(d, 32'hc6, "timer rate received");
    wr(`SSP_OFF_CONTROL, 32'h10);
    @(negedge aclk);
    check(sck_oe, 1'b0, "pins released");
    $display("test rates done");
  endtask
  task automatic t_i2c();
    wr(`SSP_OFF_CONTROL, 32'h36);
    @(posedge aclk);
    i2c_addr_match <= 1'b1;
    i2c_addr_rw <= 1'b1;
    i2c_byte_done <= 1'b1;
    @(posedge aclk);
    i2c_addr_match <= 1'b0;
    i2c_addr_rw <= 1'b0;
    i2c_byte_done <= 1'b0;
    rd(`SSP_OFF_STATUS);
    check({d[5], d[2]}, 2'b01, "address byte");
    @(posedge aclk);
    i2c_byte_done <= 1'b1;
    i2c_byte_is_data <= 1'b1;
    @(posedge aclk);
    i2c_byte_done <= 1'b0;
    i2c_byte_is_data <= 1'b0;
    rd(`SSP_OFF_STATUS);
    check({d[5], d[2]}, 2'b11, "data byte");
    rd(`SSP_OFF_CONTROL);
    check(d[6], 1'b1, "i2c overflow");
    wr(`SSP_OFF_CONTROL, 32'h3f);
    rd(`SSP_OFF_CONTROL);
    check(d, 32'h3f, "ten-bit mode");
    wr(`SSP_OFF_CONTROL, 32'h26);
    @(negedge aclk);
    check({sck_oe, sck_out}, 2'b10, "clock stretched");
    $display("test i2c done");
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Time-zero values, reset, then the scenarios
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {timer_two_tick, i2c_addr_match, i2c_addr_rw, i2c_byte_done, i2c_byte_is_data} = 5'h00;
    {num_errors, n_compared, cyc} = 96'h0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_master();
    t_slave();
    t_rates();
    t_i2c();
    final_report();
  end
endmodule // sync_serial_port_spi_bench
`default_nettype wire
